// ===== inc/stos_regs.svh
// Register map, field positions and timing constants of the trigger output select block.
// Assumes an AXI4-Lite slave with 32-bit data and one word per register.
// Function
// - Two differential backplane trigger outputs, 0 and 1, each enabled by its own bit.
// - Reading a differential line enable returns 1 when enabled, 0 when disabled.
// - Front-panel port, when enabled, pulses once after each scan closure; never when disabled.
// - Front-panel pulses are negative-going: idle high, low during the pulse.
// - Eight logic-level backplane trigger lines, 0 to 7, each enabled by its own bit.
// - Enabled logic-level line pulses low after each scan closure; disabled lines stay idle.
// - At most one of eleven outputs enabled; enabling another clears the previous one.
// - Reading the front-panel enable returns 1 when enabled, 0 when disabled.
// - Reading a logic-level line enable returns 1 when enabled, 0 when disabled.
// - Reset command disables the front-panel trigger port.
// - Reset command disables every logic-level backplane trigger line.
`ifndef STOS_REGS_SVH
`define STOS_REGS_SVH
`define STOS_ADDR_W 4
`define STOS_OFF_ENABLE 4'h0
`define STOS_OFF_CMD 4'h4
`define STOS_OFF_STATUS 4'h8
`define STOS_ENABLE_W 11
`define STOS_ENABLE_RESET 11'h000
`define STOS_DIFF_LSB 0
`define STOS_DIFF_N 2
`define STOS_LOGIC_LSB 2
`define STOS_LOGIC_N 8
`define STOS_EXT_BIT 10
`define STOS_CMD_SEL_LSB 0
`define STOS_CMD_SEL_W 4
`define STOS_CMD_ON_BIT 4
`define STOS_CMD_RST_BIT 8
`define STOS_SEL_MAX 4'hA
`define STOS_STAT_ACTIVE_BIT 0
`define STOS_STAT_COUNT_LSB 16
`define STOS_STAT_COUNT_W 16
`define STOS_PULSE_NS 80
`define STOS_CLK_NS 8
`define STOS_RESP_OKAY 2'h0
`define STOS_RESP_SLVERR 2'h2
`endif

// ===== inc/stos_pkg.sv
// Types shared by the trigger output select block.
// Assumes the constants header is included alongside.
package stos_pkg;
  typedef enum logic [1:0] {
    STOS_PULSE_IDLE = 2'b00,
    STOS_PULSE_LOW = 2'b01
  } stos_pulse_state_type;
endpackage : stos_pkg

// ===== design/stos_onehot_enable.sv
// One-hot enable register for the eleven trigger outputs.
// Assumes single-cycle write strobes from the register slave.
`timescale 1ns/1ps
`include "stos_regs.svh"
module stos_onehot_enable (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic soft_rst,
  input wire logic set_valid,
  input wire logic [`STOS_CMD_SEL_W-1:0] set_sel,
  input wire logic set_on,
  output logic [`STOS_ENABLE_W-1:0] enable
);
  typedef struct packed {
    logic [`STOS_ENABLE_W-1:0] en;
  } stos_en_state_type;
  stos_en_state_type state;
  stos_en_state_type next_state;

  function automatic logic [`STOS_ENABLE_W-1:0] stos_decode(input logic [`STOS_CMD_SEL_W-1:0] sel);
    logic [`STOS_ENABLE_W-1:0] v;
    v = '0;
    if (sel <= `STOS_SEL_MAX) begin
      v[sel] = 1'b1;
    end
    return v;
  endfunction : stos_decode

  always_comb begin
    next_state = state;
    if (soft_rst) begin
      next_state.en = `STOS_ENABLE_RESET;
    end else if (set_valid && (set_sel <= `STOS_SEL_MAX)) begin
      if (set_on) begin
        next_state.en = stos_decode(set_sel);
      end else begin
        next_state.en = state.en & ~stos_decode(set_sel);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{en: `STOS_ENABLE_RESET};
    end else begin
      state <= next_state;
    end
  end

  assign enable = state.en;

  property p_onehot;
    @(posedge core_clk) disable iff (!rst_n) $onehot0(enable);
  endproperty
  a_onehot: assert property (p_onehot) else $error("more than one trigger output enabled");

  property p_soft_rst;
    @(posedge core_clk) disable iff (!rst_n) soft_rst |=> (enable == '0);
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("reset command left an output enabled");

  property p_select;
    @(posedge core_clk) disable iff (!rst_n)
      (set_valid && set_on && !soft_rst && set_sel <= `STOS_SEL_MAX) |=> (enable == stos_decode($past(set_sel)));
  endproperty
  a_select: assert property (p_select) else $error("enable did not take the selected output alone");
endmodule : stos_onehot_enable

// ===== design/stos_pulse_gen.sv
// Pulse generator fired by scan sequencer closures; pulse_active is high for the pulse.
// Assumes closure strobes are one-cycle pulses on core_clk.
`timescale 1ns/1ps
`include "stos_regs.svh"
module stos_pulse_gen #(
  parameter int PULSE_CYCLES = 10
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic fire,
  output logic pulse_active
);
  localparam int CNT_W = $clog2(PULSE_CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(PULSE_CYCLES - 1);
  typedef struct packed {
    stos_pkg::stos_pulse_state_type st;
    logic [CNT_W-1:0] cnt;
  } stos_pg_state_type;
  stos_pg_state_type state;
  stos_pg_state_type next_state;

  always_comb begin
    next_state = state;
    case (state.st)
      stos_pkg::STOS_PULSE_IDLE: begin
        if (fire) begin
          next_state.st = stos_pkg::STOS_PULSE_LOW;
          next_state.cnt = '0;
        end
      end
      stos_pkg::STOS_PULSE_LOW: begin
        // Closures during a pulse are dropped; a scan cannot outrun relay settling
        if (state.cnt == LAST) begin
          next_state.st = stos_pkg::STOS_PULSE_IDLE;
        end else begin
          next_state.cnt = state.cnt + CNT_W'(1);
        end
      end
      default: begin
        next_state.st = stos_pkg::STOS_PULSE_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{st: stos_pkg::STOS_PULSE_IDLE, cnt: '0};
    end else begin
      state <= next_state;
    end
  end

  assign pulse_active = (state.st == stos_pkg::STOS_PULSE_LOW);

  property p_width;
    @(posedge core_clk) disable iff (!rst_n)
      $fell(pulse_active) |-> ($past(state.cnt) == LAST);
  endproperty
  a_width: assert property (p_width) else $error("pulse ended before or after its full width");

  property p_start;
    @(posedge core_clk) disable iff (!rst_n) (fire && !pulse_active) |=> pulse_active;
  endproperty
  a_start: assert property (p_start) else $error("closure did not start a pulse");
endmodule : stos_pulse_gen

// ===== design/stos_top.sv
// Trigger output select: AXI4-Lite register slave, one-hot output enables, active-low pulse outputs.
// Assumes the scan sequencer gives a one-cycle strobe per closure on core_clk.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "stos_regs.svh"
module stos_top #(
  parameter int PULSE_NS = `STOS_PULSE_NS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [`STOS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`STOS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scan_close,
  output logic [`STOS_DIFF_N-1:0] diff_backplane_trigger_line_n,
  output logic [`STOS_LOGIC_N-1:0] logic_backplane_trigger_line_n,
  output logic ext_trig_out_n
);
  localparam int PULSE_CYCLES = (PULSE_NS + `STOS_CLK_NS - 1) / `STOS_CLK_NS;

  typedef struct packed {
    logic aw_held;
    logic [`STOS_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [`STOS_ENABLE_W-1:0] trig_out;
    logic [15:0] pulse_count;
  } stos_top_state_type;
  stos_top_state_type state;
  stos_top_state_type next_state;

  logic [`STOS_ENABLE_W-1:0] enable;
  logic pulse_active;
  logic do_write;
  logic set_valid;
  logic [`STOS_CMD_SEL_W-1:0] set_sel;
  logic set_on;
  logic soft_rst;
  logic [`STOS_ENABLE_W-1:0] wr_enable_word;
  logic [`STOS_ENABLE_W-1:0] wr_diff;

  // Only the sequencer strobe fires; direct close commands never reach this block
  stos_pulse_gen #(
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_pulse (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .fire(scan_close),
    .pulse_active(pulse_active)
  );

  stos_onehot_enable u_enable (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .soft_rst(soft_rst),
    .set_valid(set_valid),
    .set_sel(set_sel),
    .set_on(set_on),
    .enable(enable)
  );

  function automatic logic [`STOS_CMD_SEL_W-1:0] stos_first_set(input logic [`STOS_ENABLE_W-1:0] v);
    logic [`STOS_CMD_SEL_W-1:0] idx;
    idx = '0;
    for (int i = `STOS_ENABLE_W - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = `STOS_CMD_SEL_W'(i);
      end
    end
    return idx;
  endfunction : stos_first_set

  function automatic logic stos_addr_ok(input logic [`STOS_ADDR_W-1:0] a);
    return (a == `STOS_OFF_ENABLE) || (a == `STOS_OFF_CMD) || (a == `STOS_OFF_STATUS);
  endfunction : stos_addr_ok

  assign s_axi_awready = !state.aw_held && !state.bvalid;
  assign s_axi_wready = !state.w_held && !state.bvalid;
  assign s_axi_arready = !state.rvalid;
  assign do_write = state.aw_held && state.w_held && !state.bvalid;
  assign wr_enable_word = state.w_data[`STOS_ENABLE_W-1:0];
  assign wr_diff = wr_enable_word ^ enable;

  // Writes to the enable word set the lowest newly named bit, or clear the current one
  always_comb begin
    set_valid = 1'b0;
    set_sel = '0;
    set_on = 1'b0;
    soft_rst = 1'b0;
    if (do_write && state.w_strb[0]) begin
      if (state.aw_addr == `STOS_OFF_CMD) begin
        soft_rst = state.w_data[`STOS_CMD_RST_BIT] && state.w_strb[1];
        set_valid = 1'b1;
        set_sel = state.w_data[`STOS_CMD_SEL_LSB +: `STOS_CMD_SEL_W];
        set_on = state.w_data[`STOS_CMD_ON_BIT];
      end else if (state.aw_addr == `STOS_OFF_ENABLE && state.w_strb[1]) begin
        set_valid = (wr_diff != '0);
        set_sel = stos_first_set(wr_diff & wr_enable_word);
        set_on = ((wr_diff & wr_enable_word) != '0);
        if (!set_on) begin
          set_sel = stos_first_set(wr_diff);
        end
      end
    end
  end

  always_comb begin
    next_state = state;
    if (s_axi_awvalid && s_axi_awready) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = stos_addr_ok(state.aw_addr) ? `STOS_RESP_OKAY : `STOS_RESP_SLVERR;
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_state.rvalid = 1'b1;
      next_state.rresp = `STOS_RESP_OKAY;
      next_state.rdata = '0;
      case (s_axi_araddr)
        `STOS_OFF_ENABLE: begin
          next_state.rdata[`STOS_ENABLE_W-1:0] = enable;
        end
        `STOS_OFF_CMD: begin
          next_state.rdata = '0;
        end
        `STOS_OFF_STATUS: begin
          next_state.rdata[`STOS_STAT_ACTIVE_BIT] = pulse_active;
          next_state.rdata[`STOS_STAT_COUNT_LSB +: `STOS_STAT_COUNT_W] = state.pulse_count;
        end
        default: begin
          next_state.rresp = `STOS_RESP_SLVERR;
        end
      endcase
    end else if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
    // Drive low only on the enabled line; registered so the pins never glitch
    next_state.trig_out = pulse_active ? enable : '0;
    if (scan_close && !pulse_active && enable != '0) begin
      next_state.pulse_count = state.pulse_count + 16'h0001;
    end
    if (soft_rst) begin
      next_state.pulse_count = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Idle high, low for the pulse
  assign diff_backplane_trigger_line_n = ~state.trig_out[`STOS_DIFF_LSB +: `STOS_DIFF_N];
  assign logic_backplane_trigger_line_n = ~state.trig_out[`STOS_LOGIC_LSB +: `STOS_LOGIC_N];
  assign ext_trig_out_n = ~state.trig_out[`STOS_EXT_BIT];
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp = state.bresp;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rresp = state.rresp;
  assign s_axi_rdata = state.rdata;
  // Another switchbox sharing a line is kept off it by the controller, not by this block

  property p_disabled_idle;
    @(posedge core_clk) disable iff (!rst_n) !enable[`STOS_EXT_BIT] |=> ext_trig_out_n;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("disabled front port pulsed");

  property p_logic_pulse;
    @(posedge core_clk) disable iff (!rst_n)
      (pulse_active && enable[`STOS_LOGIC_LSB]) |=> !logic_backplane_trigger_line_n[0];
  endproperty
  a_logic_pulse: assert property (p_logic_pulse) else $error("enabled logic line did not go low");

  property p_neg_going;
    @(posedge core_clk) disable iff (!rst_n) !pulse_active |=> (ext_trig_out_n && &logic_backplane_trigger_line_n);
  endproperty
  a_neg_going: assert property (p_neg_going) else $error("trigger low outside a pulse");

  property p_readback;
    @(posedge core_clk) disable iff (!rst_n)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == `STOS_OFF_ENABLE)
      |=> (s_axi_rvalid && s_axi_rdata[`STOS_ENABLE_W-1:0] == $past(enable));
  endproperty
  a_readback: assert property (p_readback) else $error("enable readback mismatch");
endmodule : stos_top

// ===== testbench/stos_trig_bus_model.sv
// Other instruments listening on the shared trigger lines.
// Assumes bit order diff 0..1, logic 2..9, front port 10.
`timescale 1ns/1ps
module stos_trig_bus_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [10:0] line_n,
  output logic [7:0] pulse_cnt [11],
  output logic [7:0] low_width,
  output logic overlap
);
  logic [10:0] prev_n;
  logic [7:0] run;
  // Listens only, never drives, so the device keeps the line to itself
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_n <= 11'h7FF;
      run <= 8'h00;
      low_width <= 8'h00;
      overlap <= 1'b0;
      for (int i = 0; i < 11; i++) pulse_cnt[i] <= 8'h00;
    end else begin
      prev_n <= line_n;
      if ($countones(~line_n) > 1) overlap <= 1'b1;
      for (int i = 0; i < 11; i++) begin
        if (prev_n[i] && !line_n[i]) pulse_cnt[i] <= pulse_cnt[i] + 8'h01;
      end
      if (line_n != 11'h7FF) begin
        run <= run + 8'h01;
      end else if (run != 8'h00) begin
        low_width <= run;
        run <= 8'h00;
      end
    end
  end
endmodule : stos_trig_bus_model

// ===== testbench/testbench.sv
// Self-checking bench: AXI4-Lite register calls plus scan closure strobes.
// Assumes PULSE_NS 16 gives two-cycle pulses on an 8 ns clock.
`timescale 1ns/1ps
`include "stos_regs.svh"
module testbench;
  localparam int PW = 2;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic scan_close = 1'b0;
  logic [1:0] diff_n;
  logic [7:0] logic_n;
  logic ext_n;
  logic [7:0] pulse_cnt [11];
  logic [7:0] low_width;
  logic overlap;
  logic [7:0] exp_cnt [11];
  logic [31:0] rd;
  int mismatches = 0, checks_done = 0, cycles = 0;
  always #4 core_clk = ~core_clk;
  stos_top #(.PULSE_NS(16)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .scan_close(scan_close), .diff_backplane_trigger_line_n(diff_n),
    .logic_backplane_trigger_line_n(logic_n), .ext_trig_out_n(ext_n));
  stos_trig_bus_model u_bus (.core_clk(core_clk), .rst_n(rst_n), .line_n({ext_n, logic_n, diff_n}),
    .pulse_cnt(pulse_cnt), .low_width(low_width), .overlap(overlap));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (exp !== got) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic axi_write(input logic [3:0] addr, input logic [31:0] data, input logic [1:0] resp);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    // Let an edge pass so a previous call's release is never overwritten in the same step
    @(posedge core_clk);
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, resp}, {30'h0, s_axi_bresp});
  endtask : axi_write
  task automatic axi_read(input logic [3:0] addr, input logic [1:0] resp, output logic [31:0] data);
    @(posedge core_clk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    data = s_axi_rdata;
    check("rresp", {30'h0, resp}, {30'h0, s_axi_rresp});
  endtask : axi_read
  // The strobe's second cycle lands inside the pulse and must not start another
  task automatic fire_and_check();
    @(posedge core_clk);
    scan_close <= 1'b1;
    @(posedge core_clk);
    @(posedge core_clk);
    scan_close <= 1'b0;
    repeat (PW + 6) @(posedge core_clk);
    for (int i = 0; i < 11; i++) check("pulse count", {24'h0, exp_cnt[i]}, {24'h0, pulse_cnt[i]});
  endtask : fire_and_check
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    for (int i = 0; i < 11; i++) exp_cnt[i] = 8'h00;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    check("idle lines", 32'h7FF, {21'h0, ext_n, logic_n, diff_n});
    axi_read(`STOS_OFF_ENABLE, `STOS_RESP_OKAY, rd);
    check("enable after reset", 32'h0, rd);
    fire_and_check();
    for (int i = 0; i < 11; i++) begin
      axi_write(`STOS_OFF_CMD, 32'h10 | i, `STOS_RESP_OKAY);
      axi_read(`STOS_OFF_ENABLE, `STOS_RESP_OKAY, rd);
      check("one-hot enable", 32'h1 << i, rd);
      exp_cnt[i] = exp_cnt[i] + 8'h01;
      fire_and_check();
      check("pulse width", PW, {24'h0, low_width});
    end
    check("overlap", 32'h0, {31'h0, overlap});
    axi_read(`STOS_OFF_STATUS, `STOS_RESP_OKAY, rd);
    check("pulse tally", 32'h000B0000, rd);
    axi_write(`STOS_OFF_CMD, 32'h0A, `STOS_RESP_OKAY);
    axi_read(`STOS_OFF_ENABLE, `STOS_RESP_OKAY, rd);
    check("ext off", 32'h0, rd);
    fire_and_check();
    axi_write(`STOS_OFF_ENABLE, 32'h600, `STOS_RESP_OKAY);
    axi_read(`STOS_OFF_ENABLE, `STOS_RESP_OKAY, rd);
    check("lowest wins", 32'h200, rd);
    axi_write(`STOS_OFF_CMD, 32'h1A, `STOS_RESP_OKAY);
    axi_write(`STOS_OFF_CMD, 32'h100, `STOS_RESP_OKAY);
    axi_read(`STOS_OFF_ENABLE, `STOS_RESP_OKAY, rd);
    check("reset command", 32'h0, rd);
    axi_read(`STOS_OFF_STATUS, `STOS_RESP_OKAY, rd);
    check("tally cleared", 32'h0, rd);
    fire_and_check();
    axi_write(4'hC, 32'h1, `STOS_RESP_SLVERR);
    axi_read(4'hC, `STOS_RESP_SLVERR, rd);
    check("unmapped read", 32'h0, rd);
    stop_test();
  end
endmodule : testbench
